// ### logic/pms_mode_mux.sv
// Automatic mode switching, blanking window, edge builder, output combiner and current limit for four PWM channels
//
// What this block does
// - Each channel's blanking signal rises at blanking start and falls at blanking end.
// - Edge builder uses own and next channel A and B to form two outputs.
// - Channel three takes channel zero as its next channel for edge building.
// - Each of four generated edges has its own 3-bit source selector.
// - Source codes: own A rise/fall, own B rise/fall, next A rise/fall, next B.
// - A control register steers the edge builder and holds its enable bit.
// - Combiner forms A and B outputs; selects come from the configuration sets.
// - Combiner disabled: outputs follow the channel waveforms after current limiting.
// - Combiner enabled forces high resolution off; edges fall on the 4 ns grid.
// - A select: own A, builder A, blank, own B, next A/B, blank n+1..n+3.
// - B select: own B, builder B, blank, own A, next A/B, blank n+1..n+3.
// - Combiner channel offsets n+1, n+2, n+3 wrap modulo four.
// - Two levels of automatic switching, done in hardware; the high level also needs the mid enable.
// - With switching on, duty value picks base, mid or high set.
// - Four thresholds form two upper/lower pairs giving hysteresis.
// - Base to mid above low-upper; mid back to base below low-lower.
// - Current-limit trip during A conduction ends the A pulse once it has passed the two-stage synchroniser.
// - When enabled, B pulse is cut to the truncated width of A.
// - In the low-frequency set the rectifier on-time is held fixed.
`timescale 1ns/10ps
`include "pms_consts.svh"

module pms_mode_mux
	import pms_pkg::*;
#(
	parameter int CW = 16 // Width of period counters, duty and thresholds
) (
	input  wire logic          clk,                 // 250 MHz clock
	input  wire logic          sys_rst,             // Synchronous reset, active high
	input  wire logic [5:0]    avs_address,         // Avalon byte address
	input  wire logic          avs_read,            // Avalon read request
	input  wire logic          avs_write,           // Avalon write request
	input  wire logic [31:0]   avs_writedata,       // Avalon write data
	output logic      [31:0]   avs_readdata,        // Avalon read data
	output logic               avs_waitrequest,     // Avalon wait request
	input  wire logic [3:0]    chan_a,              // Raw A waveform of each channel
	input  wire logic [3:0]    chan_b,              // Raw B waveform of each channel
	input  wire logic [4*CW-1:0] chan_cnt,          // Period counter of each channel
	input  wire logic          period_start,        // Pulse at each switching-period start
	input  wire logic [CW-1:0] loop_duty,           // Duty demand from the compensator
	input  wire logic [3:0]    cur_limit_trip,      // Comparator trip per channel, asynchronous
	output logic      [3:0]    pwm_out_first,       // Final A outputs
	output logic      [3:0]    pwm_out_second,      // Final B outputs
	output logic      [3:0]    sync_rect_drive,     // Synchronous rectifier drive
	output logic      [3:0]    hires_enable         // High resolution edge placement allowed
);

	// Register file
	logic [2:0]               ctrl;
	logic [`PMS_CFG_W-1:0]    cfg_base;
	logic [`PMS_CFG_W-1:0]    cfg_mid;
	logic [`PMS_CFG_W-1:0]    cfg_high;
	logic [`PMS_EDGE_W-1:0]   edge_builder_ctrl;
	logic [CW-1:0]            thr_lu;
	logic [CW-1:0]            thr_ll;
	logic [CW-1:0]            thr_hu;
	logic [CW-1:0]            thr_hl;
	logic [CW-1:0]            sr_on_time;
	logic [31:0]              blank_cfg [0:3];

	// Channel state
	pms_set_t                 active_set;
	pms_set_t                 next_set;
	logic [3:0]               trip_meta;
	logic [3:0]               trip_sync;
	logic [3:0]               blanking_window_signal;
	logic [3:0]               a_cut;
	logic [3:0]               a_eff;
	logic [3:0]               b_eff;
	logic [3:0]               a_q;
	logic [3:0]               b_q;
	logic [3:0]               raw_a_q;
	logic [3:0]               raw_b_q;
	logic [3:0]               eb_a;
	logic [3:0]               eb_b;
	logic [3:0]               last_trunc;
	logic [CW-1:0]            a_width [0:3];
	logic [CW-1:0]            last_width [0:3];
	logic [CW-1:0]            b_width [0:3];
	logic [CW-1:0]            sr_cnt [0:3];

	// Pick the source event for one generated edge
	function automatic logic edge_pick(input logic [2:0] sel, input logic [7:0] ev);
		edge_pick = ev[sel];
	endfunction

	// Output combiner selection for one output
	function automatic logic comb_pick(input logic [3:0] sel, input logic own, input logic eb,
		input logic blank, input logic other, input logic next_a, input logic next_b,
		input logic c1, input logic c2, input logic c3);
		case (sel)
			4'h1:    comb_pick = eb;
			4'h2:    comb_pick = blank;
			4'h3:    comb_pick = other;
			4'h4:    comb_pick = next_a;
			4'h5:    comb_pick = next_b;
			4'h6:    comb_pick = c1;
			4'h7:    comb_pick = c2;
			4'h8:    comb_pick = c3;
			default: comb_pick = own;
		endcase
	endfunction

	// Hysteresis compares: the duty must be strictly past a threshold to move
	function automatic logic duty_above(input logic [CW-1:0] duty, input logic [CW-1:0] thr);
		duty_above = duty > thr;
	endfunction

	function automatic logic duty_below(input logic [CW-1:0] duty, input logic [CW-1:0] thr);
		duty_below = duty < thr;
	endfunction

	// Active configuration set
	wire [`PMS_CFG_W-1:0] cfg = (active_set == PMS_SET_HIGH) ? cfg_high :
	                            (active_set == PMS_SET_MID)  ? cfg_mid : cfg_base;
	wire        comb_en   = cfg[`PMS_CFG_COMB_EN];
	wire        cl_en     = cfg[`PMS_CFG_CL_EN];
	wire        bmatch_en = cfg[`PMS_CFG_BMATCH];
	wire        sr_fixed  = cfg[`PMS_CFG_SR_FIXED];
	wire [3:0]  a_sel     = cfg[`PMS_CFG_ASEL_LSB +: 4];
	wire [3:0]  b_sel     = cfg[`PMS_CFG_BSEL_LSB +: 4];
	wire        mid_en    = ctrl[`PMS_CTRL_MID_EN];
	wire        high_en   = ctrl[`PMS_CTRL_MID_EN] & ctrl[`PMS_CTRL_HIGH_EN];

	// Threshold crossings of the duty demand
	wire        over_lu   = duty_above(loop_duty, thr_lu);
	wire        under_ll  = duty_below(loop_duty, thr_ll);
	wire        over_hu   = duty_above(loop_duty, thr_hu);
	wire        under_hl  = duty_below(loop_duty, thr_hl);

	// Mode selection with hysteresis
	always_comb begin
		next_set = active_set;
		case (active_set)
			PMS_SET_BASE: begin
				if (mid_en && over_lu)
					next_set = PMS_SET_MID;
			end
			PMS_SET_MID: begin
				if (under_ll)
					next_set = PMS_SET_BASE;
				else if (high_en && over_hu)
					next_set = PMS_SET_HIGH;
			end
			PMS_SET_HIGH: begin
				if (under_hl)
					next_set = PMS_SET_MID;
			end
			default: next_set = PMS_SET_BASE;
		endcase
		if (!mid_en)
			next_set = PMS_SET_BASE;
		else if (!high_en && next_set == PMS_SET_HIGH)
			next_set = PMS_SET_MID;
	end

	// Set changes only at a period boundary
	always_ff @(posedge clk) begin
		if (sys_rst)
			active_set <= PMS_SET_BASE;
		else if (period_start)
			active_set <= next_set;
	end

	// Two-stage synchroniser for the comparator trips
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trip_meta <= 4'h0;
			trip_sync <= 4'h0;
		end else begin
			trip_meta <= cur_limit_trip;
			trip_sync <= trip_meta;
		end
	end

	// Bus decode
	wire        bus_req  = avs_read | avs_write;
	wire        wr_take  = avs_write & ~avs_waitrequest;
	wire        blank_hit = (avs_address[5:4] == 2'(`PMS_OFS_BLANK0 >> 4));
	wire [1:0]  blank_idx = avs_address[3:2];
	wire [31:0] status_word = {20'h00000, a_cut, blanking_window_signal, 2'h0, active_set};

	// Read-back multiplexer, narrow registers padded with zeros
	wire [31:0] rd_mux =
		(avs_address == `PMS_OFS_CTRL)     ? {29'h0, ctrl} :
		(avs_address == `PMS_OFS_STATUS)   ? status_word :
		(avs_address == `PMS_OFS_CFG_BASE) ? {20'h0, cfg_base} :
		(avs_address == `PMS_OFS_CFG_MID)  ? {20'h0, cfg_mid} :
		(avs_address == `PMS_OFS_CFG_HIGH) ? {20'h0, cfg_high} :
		(avs_address == `PMS_OFS_EDGE)     ? {19'h0, edge_builder_ctrl} :
		(avs_address == `PMS_OFS_THR_LU)   ? {16'h0, thr_lu} :
		(avs_address == `PMS_OFS_THR_LL)   ? {16'h0, thr_ll} :
		(avs_address == `PMS_OFS_THR_HU)   ? {16'h0, thr_hu} :
		(avs_address == `PMS_OFS_THR_HL)   ? {16'h0, thr_hl} :
		(avs_address == `PMS_OFS_SR_ON)    ? {16'h0, sr_on_time} :
		blank_hit                          ? blank_cfg[blank_idx] : 32'h00000000;

	// Bus handshake: one wait cycle, then the answer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (bus_req && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? rd_mux : 32'h00000000;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Register writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl              <= `PMS_CTRL_RST;
			cfg_base          <= `PMS_CFG_RST;
			cfg_mid           <= `PMS_CFG_RST;
			cfg_high          <= `PMS_CFG_RST;
			edge_builder_ctrl <= `PMS_EDGE_RST;
			thr_lu            <= `PMS_THR_RST;
			thr_ll            <= `PMS_THR_LO_RST;
			thr_hu            <= `PMS_THR_RST;
			thr_hl            <= `PMS_THR_LO_RST;
			sr_on_time        <= `PMS_SR_ON_RST;
			for (int i = 0; i < 4; i++)
				blank_cfg[i] <= `PMS_BLANK_RST;
		end else if (wr_take) begin
			case (avs_address)
				`PMS_OFS_CTRL:     ctrl <= avs_writedata[2:0];
				`PMS_OFS_CFG_BASE: cfg_base <= avs_writedata[`PMS_CFG_W-1:0];
				`PMS_OFS_CFG_MID:  cfg_mid <= avs_writedata[`PMS_CFG_W-1:0];
				`PMS_OFS_CFG_HIGH: cfg_high <= avs_writedata[`PMS_CFG_W-1:0];
				`PMS_OFS_EDGE:     edge_builder_ctrl <= avs_writedata[`PMS_EDGE_W-1:0];
				`PMS_OFS_THR_LU:   thr_lu <= avs_writedata[CW-1:0];
				`PMS_OFS_THR_LL:   thr_ll <= avs_writedata[CW-1:0];
				`PMS_OFS_THR_HU:   thr_hu <= avs_writedata[CW-1:0];
				`PMS_OFS_THR_HL:   thr_hl <= avs_writedata[CW-1:0];
				`PMS_OFS_SR_ON:    sr_on_time <= avs_writedata[CW-1:0];
				default: begin
					if (blank_hit)
						blank_cfg[blank_idx] <= avs_writedata;
				end
			endcase
		end
	end

	// Per-channel logic
	for (genvar n = 0; n < 4; n++) begin : g_ch
		// Neighbour indices, wrapped modulo four
		localparam int N1 = (n + 1) % 4;
		localparam int N2 = (n + 2) % 4;
		localparam int N3 = (n + 3) % 4;

		// Counter compares, trip gating and raw edge detects
		wire [CW-1:0] cnt      = chan_cnt[n*CW +: CW];
		wire [CW-1:0] blk_beg  = blank_cfg[n][15:0];
		wire [CW-1:0] blk_end  = blank_cfg[n][31:16];
		wire          trip_now = cl_en & trip_sync[n] & chan_a[n];
		wire          a_rise_raw = chan_a[n] & ~raw_a_q[n];
		wire          a_fall_raw = ~chan_a[n] & raw_a_q[n];
		wire          b_rise_raw = chan_b[n] & ~raw_b_q[n];
		wire          b_stop   = bmatch_en & last_trunc[n] & (b_width[n] >= last_width[n]);
		wire          a_hold   = a_cut[n] & ~a_rise_raw; // Old cut must not eat the next pulse

		// Effective waveforms after current limiting
		assign a_eff[n] = chan_a[n] & ~a_hold & ~trip_now;
		assign b_eff[n] = chan_b[n] & ~(b_stop & ~b_rise_raw);

		// Edge events of own and next channel
		wire [7:0] ev = {b_q[N1] & ~b_eff[N1], ~b_q[N1] & b_eff[N1],
		                 a_q[N1] & ~a_eff[N1], ~a_q[N1] & a_eff[N1],
		                 b_q[n] & ~b_eff[n], ~b_q[n] & b_eff[n],
		                 a_q[n] & ~a_eff[n], ~a_q[n] & a_eff[n]};

		// Edge builder enable and per-edge strobes
		wire eb_on = edge_builder_ctrl[`PMS_EDGE_EN];
		wire ar = edge_pick(edge_builder_ctrl[`PMS_EDGE_AR_LSB +: 3], ev);
		wire af = edge_pick(edge_builder_ctrl[`PMS_EDGE_AF_LSB +: 3], ev);
		wire br = edge_pick(edge_builder_ctrl[`PMS_EDGE_BR_LSB +: 3], ev);
		wire bf = edge_pick(edge_builder_ctrl[`PMS_EDGE_BF_LSB +: 3], ev);

		// Combiner choices for this channel
		wire out_a = comb_pick(a_sel, a_eff[n], eb_a[n], blanking_window_signal[n], b_eff[n],
		                       a_eff[N1], b_eff[N1], blanking_window_signal[N1],
		                       blanking_window_signal[N2], blanking_window_signal[N3]);
		wire out_b = comb_pick(b_sel, b_eff[n], eb_b[n], blanking_window_signal[n], a_eff[n],
		                       a_eff[N1], b_eff[N1], blanking_window_signal[N1],
		                       blanking_window_signal[N2], blanking_window_signal[N3]);

		// Rectifier end: fixed on-time or end of A
		wire sr_end = sr_fixed ? (sr_cnt[n] >= sr_on_time) : ~a_eff[n];

		// Blanking window
		always_ff @(posedge clk) begin
			if (sys_rst)
				blanking_window_signal[n] <= 1'b0;
			else if (cnt == blk_beg)
				blanking_window_signal[n] <= 1'b1;
			else if (cnt == blk_end)
				blanking_window_signal[n] <= 1'b0;
		end

		// Edge history and edge builder outputs
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				a_q[n]     <= 1'b0;
				b_q[n]     <= 1'b0;
				raw_a_q[n] <= 1'b0;
				raw_b_q[n] <= 1'b0;
				eb_a[n]    <= 1'b0;
				eb_b[n]    <= 1'b0;
			end else begin
				a_q[n]     <= a_eff[n];
				b_q[n]     <= b_eff[n];
				raw_a_q[n] <= chan_a[n];
				raw_b_q[n] <= chan_b[n];
				eb_a[n]    <= eb_on & (ar | (eb_a[n] & ~af));
				eb_b[n]    <= eb_on & (br | (eb_b[n] & ~bf));
			end
		end

		// Current limit truncation and width capture
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				a_cut[n]      <= 1'b0;
				last_trunc[n] <= 1'b0;
				a_width[n]    <= '0;
				last_width[n] <= '0;
				b_width[n]    <= '0;
			end else begin
				if (trip_now)
					a_cut[n] <= 1'b1;
				else if (a_rise_raw)
					a_cut[n] <= 1'b0;
				a_width[n] <= a_rise_raw ? CW'(1) : a_width[n] + CW'(a_eff[n]);
				if (a_fall_raw) begin
					last_width[n] <= a_width[n];
					last_trunc[n] <= a_cut[n] | trip_now;
				end
				b_width[n] <= b_rise_raw ? CW'(1) : b_width[n] + CW'(b_eff[n]);
			end
		end

		// Rectifier drive
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				sync_rect_drive[n] <= 1'b0;
				sr_cnt[n]          <= '0;
			end else if (a_eff[n] && !a_q[n]) begin
				sync_rect_drive[n] <= 1'b1;
				sr_cnt[n]          <= CW'(1);
			end else if (sync_rect_drive[n]) begin
				sync_rect_drive[n] <= ~sr_end;
				sr_cnt[n]          <= sr_cnt[n] + CW'(1);
			end
		end

		// Final outputs
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				pwm_out_first[n]  <= 1'b0;
				pwm_out_second[n] <= 1'b0;
				hires_enable[n]   <= 1'b0;
			end else begin
				pwm_out_first[n]  <= comb_en ? out_a : a_eff[n];
				pwm_out_second[n] <= comb_en ? out_b : b_eff[n];
				hires_enable[n]   <= ctrl[`PMS_CTRL_HIRES] & ~comb_en;
			end
		end
	end

endmodule

// ### logic/pms_consts.svh
// Register offsets, field positions and reset values of the mode switch and edge mux block
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

`define PMS_ADDR_W         6
`define PMS_OFS_CTRL       6'h00
`define PMS_OFS_STATUS     6'h04
`define PMS_OFS_CFG_BASE   6'h08
`define PMS_OFS_CFG_MID    6'h0c
`define PMS_OFS_CFG_HIGH   6'h10
`define PMS_OFS_EDGE       6'h14
`define PMS_OFS_THR_LU     6'h18
`define PMS_OFS_THR_LL     6'h1c
`define PMS_OFS_THR_HU     6'h20
`define PMS_OFS_THR_HL     6'h24
`define PMS_OFS_SR_ON      6'h28
`define PMS_OFS_BLANK0     6'h30

`define PMS_CTRL_HIRES     0
`define PMS_CTRL_MID_EN    1
`define PMS_CTRL_HIGH_EN   2

`define PMS_CFG_ASEL_LSB   0
`define PMS_CFG_BSEL_LSB   4
`define PMS_CFG_COMB_EN    8
`define PMS_CFG_CL_EN      9
`define PMS_CFG_BMATCH     10
`define PMS_CFG_SR_FIXED   11
`define PMS_CFG_W          12

`define PMS_EDGE_AR_LSB    0
`define PMS_EDGE_AF_LSB    3
`define PMS_EDGE_BR_LSB    6
`define PMS_EDGE_BF_LSB    9
`define PMS_EDGE_EN        12
`define PMS_EDGE_W         13

`define PMS_STAT_SET_LSB   0
`define PMS_STAT_BLANK_LSB 4
`define PMS_STAT_CUT_LSB   8

`define PMS_CTRL_RST       3'h0
`define PMS_CFG_RST        12'h000
`define PMS_EDGE_RST       13'h0000
`define PMS_THR_RST        16'hffff
`define PMS_THR_LO_RST     16'h0000
`define PMS_SR_ON_RST      16'h0000
`define PMS_BLANK_RST      32'h00000000

`endif

// ### logic/pms_pkg.sv
// Types shared by the mode switch and edge mux block
package pms_pkg;
	// Active configuration set, Gray coded along base -> mid -> high
	typedef enum logic [1:0] {
		PMS_SET_BASE = 2'b00,
		PMS_SET_MID  = 2'b01,
		PMS_SET_HIGH = 2'b11
	} pms_set_t;
endpackage

// ### tb/pms_mode_mux_asserts.sv
// Port-level assertions for the mode switch and edge mux block
`timescale 1ns/10ps
module pms_mode_mux_asserts (
	input wire logic        clk,             // Clock
	input wire logic        sys_rst,         // Synchronous reset
	input wire logic        avs_read,        // Bus read
	input wire logic        avs_write,       // Bus write
	input wire logic [31:0] avs_readdata,    // Bus read data
	input wire logic        avs_waitrequest, // Bus wait
	input wire logic [3:0]  chan_a,          // Raw A waveforms
	input wire logic        period_start,    // Period pulse
	input wire logic [3:0]  cur_limit_trip,  // Comparator trips
	input wire logic [3:0]  pwm_out_first,   // Final A
	input wire logic [3:0]  pwm_out_second,  // Final B
	input wire logic [3:0]  hires_enable     // Fine placement allowed
);
	default clocking dcb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [2:0] quiet;    // Trip-free cycles, saturating
	logic [3:0] cut_seen; // A cut may still be pending per channel
	// Count cycles since the last trip so the sync pipeline is empty
	always_ff @(posedge clk) begin
		if (sys_rst || cur_limit_trip != 4'h0)
			quiet <= 3'h0;
		else if (quiet != 3'h7)
			quiet <= quiet + 3'h1;
	end
	// A trip leaves a cut until A has been low with the sync pipeline empty
	always_ff @(posedge clk) begin
		if (sys_rst)
			cut_seen <= 4'h0;
		else
			cut_seen <= cur_limit_trip | (cut_seen & (chan_a | {4{quiet != 3'h7}}));
	end
	reset_out_a: assert property (disable iff (1'b0) sys_rst |=>
		avs_waitrequest && hires_enable == 4'h0 && pwm_out_first == 4'h0 && pwm_out_second == 4'h0)
		else $error("outputs not cleared by reset");
	wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low for more than one cycle");
	answer_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("answer without a request");
	rdata_hold_a: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
		else $error("read data moved outside an answer");
	hires_same_a: assert property (hires_enable == 4'h0 || hires_enable == 4'hf)
		else $error("channels disagree on fine placement");
	hires_change_a: assert property (!$stable(hires_enable) |-> $past(period_start) || $past(period_start, 2)
		|| $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
		else $error("fine placement changed off a boundary");
	pass_first_a: assert property (quiet == 3'h7 && $past(cut_seen) == 4'h0 && hires_enable == 4'hf
		&& $past(hires_enable) == 4'hf
		|-> pwm_out_first == $past(chan_a))
		else $error("A output not the plain waveform");
	cover property (avs_read && !avs_waitrequest);
	cover property (hires_enable == 4'hf);
	cover property ($fell(pwm_out_first[0]) && chan_a[0]);
endmodule
bind pms_mode_mux pms_mode_mux_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chan_a(chan_a),
	.period_start(period_start), .cur_limit_trip(cur_limit_trip), .pwm_out_first(pwm_out_first),
	.pwm_out_second(pwm_out_second), .hires_enable(hires_enable));

// ### tb/pms_comp_model.sv
// Compensator stand-in giving duty demand and switching-period pulses
`timescale 1ns/10ps
module pms_comp_model (
	input  wire logic        clk,         // Clock
	input  wire logic        sys_rst,     // Synchronous reset
	input  wire logic        run,         // Let periods run
	input  wire logic [15:0] demand,      // Duty asked by the bench
	output logic      [15:0] loop_duty,   // Duty to the block
	output logic             period_start // One pulse per 16 cycles
);
	logic [3:0] phase; // Place within the period
	// Duty tracks demand; periods close only while running
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase <= 4'h0;
			loop_duty <= 16'h0000;
			period_start <= 1'b0;
		end else begin
			loop_duty <= demand;
			phase <= run ? phase + 4'h1 : 4'h0;
			period_start <= run && phase == 4'hf;
		end
	end
endmodule

// ### tb/pms_mode_mux_tb.sv
// Self-checking bench for the mode switch and edge mux block
`timescale 1ns/10ps
`include "pms_consts.svh"
module pms_mode_mux_tb
	import pms_pkg::*;
;
	logic        clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, run = 1'b0;
	logic [5:0]  avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic        avs_waitrequest, period_start;
	logic [3:0]  chan_a = 4'h0, chan_b = 4'h0, cur_limit_trip = 4'h0;
	logic [3:0]  pwm_out_first, pwm_out_second, sync_rect_drive, hires_enable;
	logic [63:0] chan_cnt = 64'h0;
	logic [15:0] demand = 16'h0, loop_duty;
	int          errors = 0, cmp_count = 0;
	// Clock at 250 MHz
	always #2 clk = ~clk;
	pms_mode_mux #(.CW(16)) uut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .chan_a(chan_a), .chan_b(chan_b), .chan_cnt(chan_cnt),
		.period_start(period_start), .loop_duty(loop_duty), .cur_limit_trip(cur_limit_trip),
		.pwm_out_first(pwm_out_first), .pwm_out_second(pwm_out_second), .sync_rect_drive(sync_rect_drive),
		.hires_enable(hires_enable));
	pms_comp_model u_comp (.clk(clk), .sys_rst(sys_rst), .run(run), .demand(demand), .loop_duty(loop_duty),
		.period_start(period_start));
	task automatic final_report();
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One bus access, held until wait is seen low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		if (avs_waitrequest !== 1'b0) begin
			errors++;
			final_report();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [5:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic at(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	function automatic logic [3:0] rot(input logic [3:0] x, input int k);
		logic [7:0] t;
		t = {x, x} >> k;
		return t[3:0];
	endfunction
	function automatic logic [3:0] pick(input int c, input logic [3:0] own, input logic [3:0] other);
		case (c)
			0: return own;
			2: return 4'b0101;
			3: return other;
			4: return rot(4'b0011, 1);
			5: return rot(4'b0110, 1);
			6, 7, 8: return rot(4'b0101, c - 5);
			default: return 4'h0;
		endcase
	endfunction
	task automatic t_regs();
		rd(`PMS_OFS_THR_HU);
		check("thr_rst", q, 32'h0000ffff);
		wr(6'h2c, 32'h1234);
		rd(6'h2c);
		check("unmapped", q, 32'h0);
		wr(`PMS_OFS_CTRL, 32'h1);
		rd(`PMS_OFS_CTRL);
		check("ctrl", q, 32'h1);
		at(3);
		check("hires_on", hires_enable, 4'hf);
	endtask
	task automatic t_pass();
		@(posedge clk);
		chan_a <= 4'b1010;
		chan_b <= 4'b0101;
		at(2);
		check("pass_a", pwm_out_first, 4'b1010);
		check("pass_b", pwm_out_second, 4'b0101);
	endtask
	task automatic t_comb();
		for (int c = 0; c < 4; c++)
			wr(6'(`PMS_OFS_BLANK0 + 4 * c), 32'h0020_0010);
		@(posedge clk);
		chan_cnt <= 64'h0020_0010_0020_0010;
		chan_a <= 4'b0011;
		chan_b <= 4'b0110;
		@(posedge clk);
		chan_cnt <= 64'h0005_0005_0005_0005;
		rd(`PMS_OFS_STATUS);
		check("blank", q[7:4], 4'b0101);
		for (int c = 0; c < 9; c++) begin
			wr(`PMS_OFS_CFG_BASE, 32'h100 | (c << 4) | c);
			at(3);
			check("comb_a", pwm_out_first, pick(c, 4'b0011, 4'b0110));
			check("comb_b", pwm_out_second, pick(c, 4'b0110, 4'b0011));
		end
		check("hires_off", hires_enable, 4'h0);
	endtask
	task automatic t_edge();
		logic [11:0] src [2] = '{12'o3254, 12'o7610};
		logic [3:0] da [2] = '{4'b0001, 4'b0010};
		logic [3:0] db [2] = '{4'b0100, 4'b0001};
		logic [3:0] ea [2] = '{4'b1000, 4'b0010};
		logic [3:0] eb [2] = '{4'b0100, 4'b1000};
		@(posedge clk);
		chan_a <= 4'h0;
		chan_b <= 4'h0;
		wr(`PMS_OFS_CFG_BASE, 32'h111);
		for (int p = 0; p < 2; p++) begin
			wr(`PMS_OFS_EDGE, 32'h1000 | src[p]);
			@(posedge clk);
			chan_a <= da[p];
			chan_b <= db[p];
			at(4);
			check("edge_a", pwm_out_first, ea[p]);
			check("edge_b", pwm_out_second, eb[p]);
			@(posedge clk);
			chan_a <= 4'h0;
			chan_b <= 4'h0;
			at(4);
			check("edge_a_clr", pwm_out_first, 4'h0);
			check("edge_b_clr", pwm_out_second, 4'h0);
		end
	endtask
	task automatic step(input logic [15:0] d, input pms_set_t s);
		@(posedge clk);
		demand <= d;
		run <= 1'b1;
		repeat (40) @(posedge clk);
		run <= 1'b0;
		rd(`PMS_OFS_STATUS);
		check("set", q[1:0], s);
	endtask
	task automatic t_mode();
		logic [15:0] dv [7] = '{120, 80, 40, 120, 250, 170, 140};
		pms_set_t es [7] = '{PMS_SET_MID, PMS_SET_MID, PMS_SET_BASE, PMS_SET_MID, PMS_SET_HIGH, PMS_SET_HIGH,
			PMS_SET_MID};
		wr(`PMS_OFS_THR_LU, 32'd100);
		wr(`PMS_OFS_THR_LL, 32'd50);
		wr(`PMS_OFS_THR_HU, 32'd200);
		wr(`PMS_OFS_THR_HL, 32'd150);
		wr(`PMS_OFS_CTRL, 32'h7);
		@(posedge clk);
		demand <= 16'd120;
		rd(`PMS_OFS_STATUS);
		check("no_boundary", q[1:0], PMS_SET_BASE);
		for (int i = 0; i < 7; i++)
			step(dv[i], es[i]);
		wr(`PMS_OFS_CTRL, 32'h3);
		step(16'd250, PMS_SET_MID);
	endtask
	task automatic t_limit();
		wr(`PMS_OFS_CTRL, 32'h1);
		step(16'd0, PMS_SET_BASE);
		wr(`PMS_OFS_SR_ON, 32'd5);
		wr(`PMS_OFS_CFG_BASE, 32'he00);
		@(posedge clk);
		chan_a <= 4'h1;
		at(3);
		check("sr_on", sync_rect_drive[0], 1'b1);
		at(10);
		check("sr_fixed", sync_rect_drive[0], 1'b0);
		check("a_full", pwm_out_first[0], 1'b1);
		@(posedge clk);
		cur_limit_trip <= 4'h1;
		at(6);
		check("a_cut", pwm_out_first[0], 1'b0);
		@(posedge clk);
		cur_limit_trip <= 4'h0;
		chan_a <= 4'h0;
		@(posedge clk);
		chan_b <= 4'h1;
		at(3);
		check("b_on", pwm_out_second[0], 1'b1);
		at(30);
		check("b_match", pwm_out_second[0], 1'b0);
		@(posedge clk);
		chan_a <= 4'h1;
		at(1);
		check("a_next", pwm_out_first[0], 1'b1);
	endtask
	// Reset, then the scenarios in turn
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_pass();
		t_comb();
		t_edge();
		t_mode();
		t_limit();
		final_report();
	end
endmodule
